// ---- rtl/sfb_subtract_file_from_acc_borrow.sv ----
`timescale 1ns/1ps
// Summary of operation
// - W minus file minus inverted carry
// - destination bit 0 writes W only
// - destination bit 1 writes file only
// - bank bit 0 uses access bank
// - bank bit 1 uses bank select
// - extended, access, f<=95: indexed offset
// - update N OV C DC Z flags
// - one word, four phases Q1-Q4
// - carry set subtracts only the file
module sfb_subtract_file_from_acc_borrow (
  // clock, reset, enable
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  input  wire logic        clk_en,
  // instruction issue
  input  wire logic        instr_valid,
  output logic             instr_ready,
  input  wire logic [15:0] instr_word,
  output logic             unknown_op,
  output logic             done,
  // core context sampled with the instruction
  input  wire logic        ext_set_en,
  input  wire logic [3:0]  bank_select_register,
  input  wire logic [11:0] index_base,
  // preset of working register and flags
  input  wire logic        acc_load_en,
  input  wire logic [7:0]  acc_load_data,
  input  wire logic        flags_load_en,
  input  wire logic [4:0]  flags_load_data,
  // data memory port, read data one cycle after mem_rd_en
  output logic [11:0]      mem_addr,
  output logic             mem_rd_en,
  input  wire logic [7:0]  mem_rdata,
  output logic             mem_wr_en,
  output logic [7:0]       mem_wdata,
  // architectural state
  output logic [7:0]       acc_out,
  output logic             flag_n,
  output logic             flag_ov,
  output logic             flag_z,
  output logic             flag_dc,
  output logic             flag_c
);

  // the whole block state is one packed word: one process computes it, one registers it
  // timing: take, Q1, Q2, Q3, Q4, then idle; the next offer is taken one cycle after Q4
  sfb_pkg::sfb_core_t cur_ff;     // registered state
  sfb_pkg::sfb_core_t nxt_cur;    // next state
  logic [7:0]         alu_result; // subtractor result
  logic [4:0]         alu_flags;  // subtractor flags
  logic               opc_hit;    // incoming word is this instruction
  logic               in_idle;    // sequencer waiting
  // phase flags, decoded once and shared by the strobes
  logic               in_q2;      // read phase
  logic               in_q4;      // write-back phase
  // fields of the word in flight; held in the state so a new offer cannot disturb them
  logic               dest_file;  // d bit: result goes back to the file
  logic               banked;     // a bit: bank select picks the bank
  logic [7:0]         file_addr;  // f field: 8-bit file address

  // opcode match on the upper six bits
  function automatic logic is_sub_borrow(input logic [15:0] word);
    is_sub_borrow = (word[sfb_pkg::OPC_MSB:sfb_pkg::OPC_LSB] == sfb_pkg::OPC_SUB_BORROW);
  endfunction

  // phase test, shared by the idle view and every strobe
  // one-hot codes make this a single-bit test after synthesis
  function automatic logic in_phase(input sfb_pkg::sfb_state_t cur,
                                    input sfb_pkg::sfb_state_t want);
    in_phase = (cur == want);
  endfunction

  // file address resolution from a, f and the sampled core context
  function automatic logic [11:0] resolve_addr(
    input logic        bank_bit,
    input logic [7:0]  faddr,
    input logic        ext_mode,
    input logic [3:0]  bank_sel,
    input logic [11:0] base
  );
    logic [11:0] addr;
    addr = 12'h000;
    // priority: banked first, then the indexed window, then the two access halves
    if (bank_bit) begin
      // banked form ignores the extended set entirely
      addr = {bank_sel, faddr};
    end else if (ext_mode && (faddr <= sfb_pkg::INDEX_LIMIT)) begin
      // offset wraps inside the data space on purpose; a plain adder, no saturation
      addr = base + {4'h0, faddr};
    end else if (faddr < sfb_pkg::ACCESS_SPLIT) begin
      // low half of the access bank
      addr = {sfb_pkg::ACCESS_LO_BANK, faddr};
    end else begin
      // high half of the access bank, where the special registers sit
      addr = {sfb_pkg::ACCESS_HI_BANK, faddr};
    end
    // the result is the address that Q1 registers
    resolve_addr = addr;
  endfunction

  // flag-computing subtractor; operand comes straight from memory in Q3
  // kept combinational: its settling fits inside one Q3 cycle, so no extra flop
  sfb_sub_alu u_alu (
    .acc      (cur_ff.acc),
    .operand  (mem_rdata),
    .carry_in (cur_ff.flags[sfb_pkg::FLAG_C]),
    .result   (alu_result),
    .flags    (alu_flags)
  );

  // decode of the offered word, of the current phase and of the word in flight
  assign opc_hit   = is_sub_borrow(instr_word);
  assign in_idle   = in_phase(cur_ff.state, sfb_pkg::ST_IDLE);
  assign in_q2     = in_phase(cur_ff.state, sfb_pkg::ST_Q2);
  assign in_q4     = in_phase(cur_ff.state, sfb_pkg::ST_Q4);
  assign dest_file = cur_ff.instr[sfb_pkg::DEST_BIT];
  assign banked    = cur_ff.instr[sfb_pkg::BANK_BIT];
  assign file_addr = cur_ff.instr[sfb_pkg::FADDR_MSB:sfb_pkg::FADDR_LSB];

  // next-state logic for the whole block
  always_comb begin
    // default: every field holds
    nxt_cur = cur_ff;
    case (cur_ff.state)
      sfb_pkg::ST_IDLE: begin
        // a word is taken only when it is this instruction
        // a foreign opcode is refused here and leaves no trace in the state
        if (instr_valid && opc_hit) begin
          // context latched with the word, not in Q1, so it cannot shift mid-instruction
          nxt_cur.instr      = instr_word;
          nxt_cur.ext_mode   = ext_set_en;
          nxt_cur.bank_sel   = bank_select_register;
          nxt_cur.index_base = index_base;
          nxt_cur.state      = sfb_pkg::ST_Q1;
        end
        // presets only while idle so an instruction in flight sees stable values
        // a preset in the same cycle as a take still lands before Q3 uses it
        if (acc_load_en) begin
          nxt_cur.acc = acc_load_data;
        end
        if (flags_load_en) begin
          nxt_cur.flags = flags_load_data;
        end
      end
      sfb_pkg::ST_Q1: begin
        // decode: resolve the operand address
        // registered so mem_addr is glitch free from Q2 on
        nxt_cur.addr  = resolve_addr(banked, file_addr,
                                     cur_ff.ext_mode, cur_ff.bank_sel,
                                     cur_ff.index_base);
        nxt_cur.state = sfb_pkg::ST_Q2;
      end
      sfb_pkg::ST_Q2: begin
        // read strobe is out this phase
        // the memory answers one cycle after the strobe, so nothing to compute
        nxt_cur.state = sfb_pkg::ST_Q3;
      end
      sfb_pkg::ST_Q3: begin
        // process: capture result and flags
        // the operand is on the memory port only in this phase
        // result and flags are held until Q4 writes them together
        nxt_cur.result    = alu_result;
        nxt_cur.new_flags = alu_flags;
        nxt_cur.state     = sfb_pkg::ST_Q4;
      end
      sfb_pkg::ST_Q4: begin
        // write destination and status together
        // flags follow the result for both destinations
        if (!dest_file) begin
          nxt_cur.acc = cur_ff.result;
        end
        nxt_cur.flags = cur_ff.new_flags;
        nxt_cur.state = sfb_pkg::ST_IDLE;
      end
      default: begin
        // illegal code: return to idle
        // unreachable with one-hot codes unless a flop is upset
        nxt_cur.state = sfb_pkg::ST_IDLE;
      end
    endcase
  end

  // single state register; clk_en freezes everything
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      // cleared wholesale first, then fields with named reset values
      cur_ff            <= '0;
      cur_ff.state      <= sfb_pkg::ST_IDLE;
      cur_ff.acc        <= sfb_pkg::ACC_RST;
      cur_ff.flags      <= sfb_pkg::FLAGS_RST;
    end else if (clk_en) begin
      // a low enable holds every field, the phase included
      cur_ff <= nxt_cur;
    end
  end

  // handshake outputs, combinational and gated by the enable
  // gating keeps a frozen cycle from repeating a read or a write
  // instr_ready stays ungated: it only reports the phase, and nothing is taken while frozen
  assign instr_ready = in_idle;
  assign unknown_op  = clk_en && in_idle && instr_valid && !opc_hit;
  assign done        = clk_en && in_q4;
  assign mem_rd_en   = clk_en && in_q2;
  // file written only for destination 1
  assign mem_wr_en   = clk_en && in_q4 && dest_file;

  // data outputs straight from flops
  // acc and flags change only at the edge that ends Q4, or at a preset taken while idle
  // mem_addr holds from Q2 until the next instruction resolves a new one
  assign mem_addr  = cur_ff.addr;
  assign mem_wdata = cur_ff.result;
  assign acc_out   = cur_ff.acc;
  // flag ports are slices of the one status word
  assign flag_n    = cur_ff.flags[sfb_pkg::FLAG_N];
  assign flag_ov   = cur_ff.flags[sfb_pkg::FLAG_OV];
  assign flag_z    = cur_ff.flags[sfb_pkg::FLAG_Z];
  assign flag_dc   = cur_ff.flags[sfb_pkg::FLAG_DC];
  assign flag_c    = cur_ff.flags[sfb_pkg::FLAG_C];

endmodule // sfb_subtract_file_from_acc_borrow

// ---- pkg/sfb_pkg.sv ----
package sfb_pkg;

  // instruction word layout
  localparam int          INSTR_W         = 16;
  localparam int          OPC_MSB         = 15;
  localparam int          OPC_LSB         = 10;
  localparam logic [5:0]  OPC_SUB_BORROW  = 6'h15;
  localparam int          DEST_BIT        = 9;
  localparam int          BANK_BIT        = 8;
  localparam int          FADDR_MSB       = 7;
  localparam int          FADDR_LSB       = 0;

  // data memory addressing
  localparam int          ADDR_W          = 12;
  localparam int          BANK_SEL_W      = 4;
  localparam logic [7:0]  ACCESS_SPLIT    = 8'h60;
  localparam logic [7:0]  INDEX_LIMIT     = 8'h5F;
  localparam logic [3:0]  ACCESS_LO_BANK  = 4'h0;
  localparam logic [3:0]  ACCESS_HI_BANK  = 4'hF;

  // reset values
  localparam logic [7:0]  ACC_RST         = 8'h00;
  localparam logic [4:0]  FLAGS_RST       = 5'h00;

  // flag positions within the packed status word {n, ov, z, dc, c}
  localparam int          FLAG_C          = 0;
  localparam int          FLAG_DC         = 1;
  localparam int          FLAG_Z          = 2;
  localparam int          FLAG_OV         = 3;
  localparam int          FLAG_N          = 4;

  // instruction cycle phases, one-hot
  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_Q1   = 5'b00010,
    ST_Q2   = 5'b00100,
    ST_Q3   = 5'b01000,
    ST_Q4   = 5'b10000
  } sfb_state_t;

  // whole state of the sequencer
  typedef struct packed {
    sfb_state_t        state;
    logic [15:0]       instr;
    logic              ext_mode;
    logic [3:0]        bank_sel;
    logic [11:0]       index_base;
    logic [11:0]       addr;
    logic [7:0]        result;
    logic [4:0]        new_flags;
    logic [7:0]        acc;
    logic [4:0]        flags;
  } sfb_core_t;

endpackage

// ---- rtl/sfb_sub_alu.sv ----
`timescale 1ns/1ps
// borrow subtractor: acc - operand - !carry, with status flags
module sfb_sub_alu (
  // operands
  input  wire logic [7:0] acc,
  input  wire logic [7:0] operand,
  input  wire logic       carry_in,
  // result
  output logic [7:0]      result,
  output logic [4:0]      flags
);

  logic [8:0] full_sum;   // two's complement sum with carry out
  logic [4:0] nib_sum;    // low nibble sum, bit 4 is the digit carry

  // subtraction done as acc + ~operand + carry; carry clear means a borrow
  always_comb begin
    full_sum = {1'b0, acc} + {1'b0, ~operand} + {8'h00, carry_in};
    nib_sum  = {1'b0, acc[3:0]} + {1'b0, ~operand[3:0]} + {4'h0, carry_in};
    result   = full_sum[7:0];
    // carry set means no borrow, so a set carry on entry subtracts nothing extra
    flags[sfb_pkg::FLAG_C]  = full_sum[8];
    flags[sfb_pkg::FLAG_DC] = nib_sum[4];
    flags[sfb_pkg::FLAG_Z]  = (full_sum[7:0] == 8'h00);
    // signed overflow: operands differ in sign and result sign differs from acc
    flags[sfb_pkg::FLAG_OV] = (acc[7] != operand[7]) && (full_sum[7] != acc[7]);
    flags[sfb_pkg::FLAG_N]  = full_sum[7];
  end

endmodule // sfb_sub_alu

// ---- verif/sfb_chk_asserts.sv ----
`timescale 1ns/1ps
// port-level checker; a frozen clock enable suspends every check
module sfb_chk (
  input wire logic        core_clk, sys_rst, clk_en, instr_valid, instr_ready,
  input wire logic        unknown_op, done, mem_rd_en, mem_wr_en, flag_n, flag_z, flag_c,
  input wire logic [15:0] instr_word,
  input wire logic [3:0]  bank_select_register,
  input wire logic [11:0] mem_addr,
  input wire logic [7:0]  mem_rdata, mem_wdata, acc_out
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst || !clk_en);
  wire hit   = instr_valid && instr_ready;  // offer while idle
  wire op_ok = instr_word[15:10] == sfb_pkg::OPC_SUB_BORROW;
  property p_take; hit && op_ok |=> !instr_ready [*3] ##1 done; endproperty
  a_take: assert property (p_take) else $error("no q4 four cycles after take");
  property p_rd; mem_rd_en |=> !done ##1 done; endproperty
  a_rd: assert property (p_rd) else $error("read not in q2");
  property p_wr; mem_wr_en |-> done; endproperty
  a_wr: assert property (p_wr) else $error("file write outside q4");
  property p_d1; done && mem_wr_en |=> $stable(acc_out); endproperty
  a_d1: assert property (p_d1) else $error("acc changed on file write");
  property p_d0; done && !mem_wr_en |=> acc_out == $past(mem_wdata); endproperty
  a_d0: assert property (p_d0) else $error("acc not loaded");
  property p_zn;
    done |=> flag_z == ($past(mem_wdata) == 8'h00) && flag_n == $past(mem_wdata[7]);
  endproperty
  a_zn: assert property (p_zn) else $error("zero or negative flag wrong");
  // the operand arrives in q3 while acc and carry still hold their entry values
  property p_sub;
    mem_rd_en ##1 1'b1 |=> mem_wdata ==
      8'($past(acc_out) - $past(mem_rdata) - 8'(!$past(flag_c)));
  endproperty
  a_sub: assert property (p_sub) else $error("difference wrong");
  property p_bank;
    hit && op_ok && instr_word[8] |-> ##2
      mem_addr == {$past(bank_select_register, 2), $past(instr_word[7:0], 2)};
  endproperty
  a_bank: assert property (p_bank) else $error("banked address wrong");
  property p_unk; hit && !op_ok |-> unknown_op ##1 instr_ready; endproperty
  a_unk: assert property (p_unk) else $error("foreign opcode not refused");
endmodule // sfb_chk

bind sfb_subtract_file_from_acc_borrow sfb_chk u_chk (.core_clk, .sys_rst, .clk_en,
  .instr_valid, .instr_ready, .unknown_op, .done, .mem_rd_en, .mem_wr_en, .flag_n,
  .flag_z, .flag_c, .instr_word, .bank_select_register, .mem_addr, .mem_rdata,
  .mem_wdata, .acc_out);

// ---- verif/sfb_testbench.sv ----
`timescale 1ns/1ps
// drives instructions, notes expectations, checks them when done shows
module testbench;
  logic        core_clk = 0, sys_rst = 1, clk_en = 1, instr_valid = 0, ext_set_en = 0;
  logic        acc_load_en = 0, flags_load_en = 0;
  logic [15:0] instr_word = 16'h0000;
  logic [3:0]  bank_select_register = 4'h0;
  logic [11:0] index_base = 12'h000, exp_addr, mem_addr;
  logic [7:0]  acc_load_data = 8'h00, mem_rdata = 8'h00, fv, mem_wdata, acc_out;
  logic [4:0]  flags_load_data = 5'h00;
  logic        instr_ready, unknown_op, done, mem_rd_en, mem_wr_en;
  logic        flag_n, flag_ov, flag_z, flag_dc, flag_c;
  logic [31:0] seed = 32'h0000_3912, cyc = 0;
  logic [21:0] n, notes[$];  // {d, result, acc after, flags after}
  int          err_count = 0, compares = 0;

  sfb_subtract_file_from_acc_borrow uut (.core_clk, .sys_rst, .clk_en, .instr_valid,
    .instr_ready, .instr_word, .unknown_op, .done, .ext_set_en, .bank_select_register,
    .index_base, .acc_load_en, .acc_load_data, .flags_load_en, .flags_load_data,
    .mem_addr, .mem_rd_en, .mem_rdata, .mem_wr_en, .mem_wdata, .acc_out, .flag_n,
    .flag_ov, .flag_z, .flag_dc, .flag_c);

  initial forever #25 core_clk = ~core_clk;

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic chk(input logic [11:0] got, exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic finish_test();
    $display("compares=%0d err_count=%0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // operand only in the cycle after the strobe; toggling otherwise exposes stale reads
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (mem_rd_en) chk(mem_addr, exp_addr);
    mem_rdata <= mem_rd_en ? fv : ~mem_rdata;
    if (cyc == 2000) begin
      err_count++;
      finish_test();
    end
  end

  // q4 outputs first, then the state one cycle later
  always @(negedge core_clk) if (done) begin
    n = notes.pop_front();
    chk(mem_wdata, n[20:13]);
    chk(mem_wr_en, n[21]);
    @(negedge core_clk);
    chk(acc_out, n[12:5]);
    chk({flag_n, flag_ov, flag_z, flag_dc, flag_c}, n[4:0]);
  end

  // preset w and flags, then offer one instruction with random bank and base
  task automatic run(input logic d, a, e, input logic [7:0] f, w, v, input logic [4:0] fl);
    logic [8:0]  s;
    logic [4:0]  h;
    logic [3:0]  b;
    logic [11:0] x;
    // plain difference with borrow; a set top bit means a borrow came out
    s = {1'b0, w} - {1'b0, v} - 9'(!fl[0]);
    h = {1'b0, w[3:0]} - {1'b0, v[3:0]} - 5'(!fl[0]);
    b = 4'(xs());
    x = 12'(xs());
    exp_addr = a ? {b, f} : (e && f <= 8'h5F) ? x + 12'(f) : {(f < 8'h60) ? 4'h0 : 4'hF, f};
    fv = v;
    @(posedge core_clk);
    acc_load_en <= 1;
    acc_load_data <= w;
    flags_load_en <= 1;
    flags_load_data <= fl;
    @(posedge core_clk);
    acc_load_en <= 0;
    flags_load_en <= 0;
    instr_valid <= 1;
    instr_word <= {sfb_pkg::OPC_SUB_BORROW, d, a, f};
    ext_set_en <= e;
    bank_select_register <= b;
    index_base <= x;
    notes.push_back({d, s[7:0], d ? w : s[7:0], s[7], (w[7] != v[7]) && (s[7] != w[7]),
                     s[7:0] == 8'h00, !h[4], !s[8]});
    @(posedge core_clk);
    instr_valid <= 0;
    repeat (5) @(posedge core_clk);
  endtask

  initial begin
    logic [31:0] r;
    repeat (20) @(posedge core_clk);
    sys_rst <= 0;
    @(negedge core_clk);
    chk({acc_out, instr_ready, flag_c}, 12'h002);
    run(1, 0, 0, 8'h10, 8'h02, 8'h03, 5'h01);
    run(0, 0, 0, 8'h70, 8'h05, 8'h02, 5'h01);
    run(0, 1, 0, 8'h33, 8'h02, 8'h01, 5'h00);
    run(1, 0, 1, 8'h5F, 8'h80, 8'h01, 5'h01);
    run(0, 0, 1, 8'h60, 8'h7F, 8'hFF, 5'h1E);
    $display("directed tests done");
    @(posedge core_clk);
    instr_valid <= 1;
    instr_word <= 16'h0000;
    @(negedge core_clk);
    chk(unknown_op, 1'b1);
    @(posedge core_clk);
    instr_valid <= 0;
    repeat (2) @(negedge core_clk);
    chk(instr_ready, 1'b1);
    $display("opcode test done");
    // enable low: a matching offer and a preset must both be ignored
    @(posedge core_clk);
    clk_en <= 0;
    instr_valid <= 1;
    instr_word <= {sfb_pkg::OPC_SUB_BORROW, 2'b00, 8'h20};
    acc_load_en <= 1;
    acc_load_data <= 8'hA5;
    repeat (3) @(negedge core_clk);
    chk({acc_out, instr_ready, done, mem_rd_en, unknown_op}, 12'h7F8);
    @(posedge core_clk);
    clk_en <= 1;
    instr_valid <= 0;
    acc_load_en <= 0;
    repeat (2) @(negedge core_clk);
    chk({acc_out, instr_ready, done, mem_rd_en, unknown_op}, 12'h7F8);
    $display("enable test done");
    repeat (60) begin
      r = xs();
      run(r[0], r[1], r[2], r[15:8], r[23:16], r[31:24], r[7:3]);
    end
    $display("random tests done");
    repeat (3) @(posedge core_clk);
    chk(12'(notes.size()), 12'h000);
    finish_test();
  end
endmodule // testbench
